// ===== hw/duart_sleep_ctrl.sv
// Sleep, power isolation, loopback and register decode for a dual UART
// Function
// R1 - Sleep only when no interrupts, both sleep enables set, no modem deltas, RX idle.
// R2 - Oscillator output stops toggling while asleep.
// R3 - Without isolation, wake on RX start edge, transmit load, or modem input change.
// R4 - Waking with sleep enabled raises interrupt reading 0x1; status read clears it.
// R5 - Return to sleep automatically once all interrupting conditions are cleared.
// R6 - Host reads modem status after a modem wake so sleep may resume.
// R7 - Sleep keeps recurring until the sleep enable bit is cleared.
// R8 - Isolation starts when the select pin is high and the device sleeps.
// R9 - Isolation gates off all host address, data and strobe inputs.
// R10 - Isolated device wakes only on RX start edge or modem change.
// R11 - Isolation recurs after modem status read and all conditions cleared.
// R12 - Isolation lasts until sleep enable cleared or select pin low.
// R13 - Modem control bit 4 places the channel in internal loopback.
// R14 - In loopback transmit shifter output feeds receive shifter input.
// R15 - In loopback TX, RTS, DTR held static; modem inputs ignored.
// R16 - Hardware handshake flow control is switched off during loopback.
// R17 - Address 0, divisor latch off: read receive data, write transmit data.
// R18 - Address 2 reaches fractional divisor when latch on, not 0xBF, enhanced set.
// R19 - Zero divisor with latch on: addresses 0 and 1 read revision and identity.
// R20 - Address 2 outside 0xBF reads interrupt status, writes FIFO control.
// R21 - Address 7 reads scratch or FIFO level per feature bit; writes mode select.
// R22 - With 0xBF: trigger/count, feature, enhanced, and four flow characters.
`timescale 1ns/1ns
module duart_sleep_ctrl #(
    parameter logic [7:0] REVISION_VALUE = 8'h5A, // Arbitrary value
    parameter logic [7:0] IDENT_VALUE = 8'hA5 // Arbitrary value
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic chan_a_select_n_i,
    input wire logic chan_b_select_n_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic power_isolate_sel_i,
    input wire logic [1:0] rx_i,
    input duart_pkg::modem_type [1:0] modem_n_i,
    input wire logic [1:0] tx_shift_i,
    input wire logic [1:0] core_int_i,
    input duart_pkg::core_status_type [1:0] core_status_i,
    output logic [1:0] rx_shift_o,
    output logic [1:0] tx_o,
    output logic [1:0] rts_n_o,
    output logic [1:0] dtr_n_o,
    output logic [1:0] hw_flow_o,
    output logic [1:0] thr_load_o,
    output logic [1:0] int_o,
    output logic osc_output_o,
    output logic sleep_o,
    output logic isolate_o
);
    import duart_pkg::*;

    // ==========================================================
    // Reset release and input synchronisers
    logic [1:0] rst_pipe_reg;
    logic rst_n;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // Every host bus, select, RX and modem pin is asynchronous to clock_i, so all pass two flops
    localparam int SW = 3 + 8 + 4 + 1 + 2 + 8;
    logic [SW-1:0] sync1_reg, sync2_reg;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= {SW{1'b1}};
            sync2_reg <= {SW{1'b1}};
        end else begin
            sync1_reg <= {addr_i, data_i, chan_a_select_n_i, chan_b_select_n_i,
                write_strobe_n_i, read_strobe_n_i, power_isolate_sel_i, rx_i, modem_n_i};
            sync2_reg <= sync1_reg;
        end
    end
    logic [2:0] s_addr;
    logic [7:0] s_data;
    logic s_csa_n, s_csb_n, s_wr_n, s_rd_n, s_iso_pin;
    logic [1:0] s_rx;
    modem_type [1:0] s_modem_n;
    assign {s_addr, s_data, s_csa_n, s_csb_n, s_wr_n, s_rd_n, s_iso_pin, s_rx,
        s_modem_n} = sync2_reg;

    // ==========================================================
    // Bus strobe edges; isolation blanks them all
    logic wr_n_d_reg, rd_n_d_reg;
    logic sleep_reg, isolate_reg;
    logic bus_open, chan, cs_any, wr_pulse, rd_pulse;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_n_d_reg <= 1'b1;
            rd_n_d_reg <= 1'b1;
        end else begin
            wr_n_d_reg <= s_wr_n;
            rd_n_d_reg <= s_rd_n;
        end
    end
    assign bus_open = !isolate_reg; // R9
    assign cs_any = !s_csa_n || !s_csb_n;
    assign chan = s_csa_n; // Channel A wins when both selects are low
    // Write commits on the trailing edge so data has settled
    assign wr_pulse = bus_open && cs_any && s_wr_n && !wr_n_d_reg; // R9
    assign rd_pulse = bus_open && cs_any && !s_rd_n && rd_n_d_reg; // R9

    // ==========================================================
    // Register storage, two channels of indexed flops
    logic [7:0] regs_reg [2][NUM_REGS];
    logic [7:0] line_control [2], interrupt_enable [2], modem_control [2], enhanced_function [2], fct [2];
    logic [1:0] loop, enh, dlab, wake_int_reg;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            line_control[c] = regs_reg[c][IX_LCR];
            interrupt_enable[c] = regs_reg[c][IX_IER];
            modem_control[c] = regs_reg[c][IX_MCR];
            enhanced_function[c] = regs_reg[c][IX_EFR];
            fct[c] = regs_reg[c][IX_FCT];
            loop[c] = modem_control[c][MCR_LOOP_BIT]; // R13
            enh[c] = line_control[c] == LCR_ENHANCED;
            dlab[c] = line_control[c][LCR_DIV_BIT] && !enh[c];
        end
    end

    // Write decode: storage index and whether the address is writable
    logic [4:0] wr_ix;
    logic wr_ok;
    logic [7:0] we;
    assign we = enhanced_function[chan];
    always_comb begin
        wr_ok = 1'b1;
        wr_ix = 5'(IX_THR);
        unique case (s_addr)
            ADDR_DATA: wr_ix = enh[chan] ? 5'(IX_TRG)
                : dlab[chan] ? 5'(IX_DLL) : 5'(IX_THR); // R17 R22
            ADDR_IER: wr_ix = enh[chan] ? 5'(IX_FCT)
                : dlab[chan] ? 5'(IX_DLM) : 5'(IX_IER); // R22
            ADDR_ISR: wr_ix = enh[chan] ? 5'(IX_EFR)
                : (dlab[chan] && we[EFR_ENH_BIT]) ? 5'(IX_DLD) : 5'(IX_FCR); // R18 R20
            ADDR_LCR: wr_ix = 5'(IX_LCR);
            ADDR_MCR: wr_ix = enh[chan] ? 5'(IX_XN1) : 5'(IX_MCR); // R22
            ADDR_LSR: begin
                wr_ix = 5'(IX_XN2);
                wr_ok = enh[chan]; // Line status is read-only
            end
            ADDR_MSR: begin
                wr_ix = 5'(IX_XF1);
                wr_ok = enh[chan];
            end
            ADDR_SPR: wr_ix = enh[chan] ? 5'(NUM_REGS - 1) : 5'(IX_EMS); // R21 R22
        endcase
    end

    // Scratch pad shares address 7 writes with mode select, so it is
    // loaded from the same byte: the mode select write reaches both
    logic [4:0] wr_slot;
    assign wr_slot = wr_ix;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < 2; c++) begin
                for (int i = 0; i < NUM_REGS; i++) begin
                    regs_reg[c][i] <= REG_RESET;
                end
            end
        end else if (wr_pulse && wr_ok) begin
            regs_reg[chan][wr_slot] <= s_data; // R17 R18 R20 R21 R22
            if (wr_slot == 5'(IX_EMS)) begin
                regs_reg[chan][IX_SPR] <= s_data;
            end
        end
    end

    // Transmit load pulse toward each channel's FIFO
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            thr_load_o <= 2'h0;
        end else begin
            thr_load_o <= 2'h0;
            if (wr_pulse && wr_slot == 5'(IX_THR) && s_addr == ADDR_DATA) begin
                thr_load_o[chan] <= 1'b1; // R17
            end
        end
    end

    // ==========================================================
    // Modem status: loopback substitutes the control bits for the pins
    modem_type [1:0] modem_lvl, modem_prev_reg;
    logic [3:0] delta_reg [2];
    logic [1:0] modem_chg, msr_rd, isr_rd;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            modem_lvl[c] = loop[c] ? modem_type'({modem_control[c][3:2], modem_control[c][0], modem_control[c][1]})
                : modem_type'(~s_modem_n[c]); // R15
            modem_chg[c] = !loop[c] && (modem_lvl[c] != modem_prev_reg[c]); // R15
            msr_rd[c] = rd_pulse && chan == c[0] && s_addr == ADDR_MSR && !enh[c];
            isr_rd[c] = rd_pulse && chan == c[0] && s_addr == ADDR_ISR && !enh[c]
                && !(dlab[c] && enhanced_function[c][EFR_ENH_BIT]);
        end
    end
    // A change in the read cycle still survives: set wins over clear
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            modem_prev_reg <= '0;
            delta_reg <= '{default: 4'h0};
        end else begin
            for (int c = 0; c < 2; c++) begin
                modem_prev_reg[c] <= modem_lvl[c];
                delta_reg[c] <= (msr_rd[c] ? 4'h0 : delta_reg[c])
                    | (modem_chg[c] ? 4'(modem_lvl[c] ^ modem_prev_reg[c]) : 4'h0); // R6
            end
        end
    end

    // ==========================================================
    // Sleep and isolation control
    logic [1:0] rx_prev_reg, rx_fall;
    logic quiet, wake_evt, host_load;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev_reg <= 2'h3;
        end else begin
            rx_prev_reg <= s_rx;
        end
    end
    assign rx_fall = rx_prev_reg & ~s_rx;
    assign host_load = wr_pulse && s_addr == ADDR_DATA && !enh[chan] && !dlab[chan];
    // The write term is already dead under isolation, since bus_open is low
    assign wake_evt = (|rx_fall) || (|modem_chg) || host_load; // R3 R10
    // Pending interrupts of either channel, including our own wake flag, hold us awake
    assign quiet = !(|core_int_i) && !(|wake_int_reg)
        && interrupt_enable[0][IER_SLEEP_BIT] && interrupt_enable[1][IER_SLEEP_BIT]
        && delta_reg[0] == 4'h0 && delta_reg[1] == 4'h0 && (&s_rx); // R1 R5 R6

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sleep_reg <= 1'b0;
        end else if (sleep_reg) begin
            // Clearing a sleep enable also ends sleep
            sleep_reg <= !wake_evt && interrupt_enable[0][IER_SLEEP_BIT] && interrupt_enable[1][IER_SLEEP_BIT]; // R3 R7
        end else begin
            sleep_reg <= quiet && !wake_evt; // R1 R5 R7
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            isolate_reg <= 1'b0;
        end else begin
            // Follows sleep while the select pin is high, so it recurs whenever sleep does with the pin high
            isolate_reg <= sleep_reg && !wake_evt && s_iso_pin
                && interrupt_enable[0][IER_SLEEP_BIT] && interrupt_enable[1][IER_SLEEP_BIT]; // R8 R11 R12
        end
    end

    // Wake interrupt per channel; a fresh wake beats a simultaneous status read
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            wake_int_reg <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (sleep_reg && wake_evt && interrupt_enable[c][IER_SLEEP_BIT]) begin
                    wake_int_reg[c] <= 1'b1; // R4
                end else if (isr_rd[c]) begin
                    wake_int_reg[c] <= 1'b0; // R4
                end
            end
        end
    end

    // Oscillator stand-in: a divided clock that freezes while asleep
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_output_o <= 1'b0;
        end else if (!sleep_reg) begin
            osc_output_o <= !osc_output_o; // R2
        end
    end

    // ==========================================================
    // Read mux and bus data output
    logic [7:0] rd_val;
    logic [7:0] rg [NUM_REGS];
    core_status_type st;
    logic zdiv;
    assign rg = regs_reg[chan];
    assign st = core_status_i[chan];
    assign zdiv = rg[IX_DLL] == DIV_ZERO && rg[IX_DLM] == DIV_ZERO;
    always_comb begin
        rd_val = REG_RESET;
        unique case (s_addr)
            ADDR_DATA: rd_val = enh[chan] ? st.fifo_count : !dlab[chan] ? st.rx_data
                : zdiv ? REVISION_VALUE : rg[IX_DLL]; // R17 R19 R22
            ADDR_IER: rd_val = enh[chan] ? fct[chan] : !dlab[chan] ? interrupt_enable[chan]
                : zdiv ? IDENT_VALUE : rg[IX_DLM]; // R19 R22
            ADDR_ISR: rd_val = enh[chan] ? enhanced_function[chan]
                : (dlab[chan] && enhanced_function[chan][EFR_ENH_BIT]) ? rg[IX_DLD]
                : wake_int_reg[chan] ? {st.int_status[7:4], ISR_WAKE_CODE}
                : st.int_status; // R4 R18 R20 R22
            ADDR_LCR: rd_val = line_control[chan];
            ADDR_MCR: rd_val = enh[chan] ? rg[IX_XN1] : modem_control[chan]; // R22
            ADDR_LSR: rd_val = enh[chan] ? rg[IX_XN2] : st.line_status; // R22
            ADDR_MSR: rd_val = enh[chan] ? rg[IX_XF1] : {modem_lvl[chan], delta_reg[chan]};
            ADDR_SPR: rd_val = enh[chan] ? rg[NUM_REGS - 1]
                : fct[chan][FEATURE_CONTROL_LVL_BIT] ? st.fifo_level : rg[IX_SPR]; // R21 R22
        endcase
    end

    // Data is latched at the strobe's leading edge and driven while it stays low
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            data_o <= REG_RESET;
            data_oe_o <= 1'b0;
        end else begin
            if (rd_pulse) begin
                data_o <= rd_val;
            end
            data_oe_o <= bus_open && cs_any && !s_rd_n; // R9
        end
    end

    // ==========================================================
    // Serial pins, loopback and registered status outputs
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift_o <= 2'h3;
            tx_o <= 2'h3;
            rts_n_o <= 2'h3;
            dtr_n_o <= 2'h3;
            hw_flow_o <= 2'h0;
            int_o <= 2'h0;
            sleep_o <= 1'b0;
            isolate_o <= 1'b0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                rx_shift_o[c] <= loop[c] ? tx_shift_i[c] : s_rx[c]; // R14
                // Marking level keeps the far receiver free of false breaks
                tx_o[c] <= loop[c] ? 1'b1 : tx_shift_i[c]; // R15
                rts_n_o[c] <= loop[c] ? 1'b1 : !modem_control[c][1]; // R15
                dtr_n_o[c] <= loop[c] ? 1'b1 : !modem_control[c][0]; // R15
                hw_flow_o[c] <= !loop[c]
                    && (enhanced_function[c][EFR_CTS_BIT] || enhanced_function[c][EFR_RTS_BIT]); // R16
                int_o[c] <= wake_int_reg[c] || core_int_i[c]; // R4
            end
            sleep_o <= sleep_reg; // R2
            isolate_o <= isolate_reg; // R8
        end
    end

    // ==========================================================
    // Checks
    sequence s_woke;
        sleep_reg && wake_evt;
    endsequence
    property p_enter_needs_quiet;
        @(posedge clock_i) disable iff (!rst_n) $rose(sleep_reg) |-> $past(quiet);
    endproperty
    a_enter_needs_quiet: assert property (p_enter_needs_quiet) else $error("unquiet sleep"); // R1
    property p_osc_frozen;
        @(posedge clock_i) disable iff (!rst_n) sleep_reg ##1 sleep_reg |-> $stable(osc_output_o);
    endproperty
    a_osc_frozen: assert property (p_osc_frozen) else $error("oscillator ran asleep"); // R2
    property p_wake_leaves;
        @(posedge clock_i) disable iff (!rst_n) s_woke |=> !sleep_reg;
    endproperty
    a_wake_leaves: assert property (p_wake_leaves) else $error("wake ignored"); // R3
    property p_wake_int;
        @(posedge clock_i) disable iff (!rst_n)
            s_woke and interrupt_enable[0][IER_SLEEP_BIT] |=> wake_int_reg[0] ##1 int_o[0];
    endproperty
    a_wake_int: assert property (p_wake_int) else $error("wake interrupt missing"); // R4
    property p_isr_clear;
        @(posedge clock_i) disable iff (!rst_n)
            isr_rd[1] && !(sleep_reg && wake_evt) |=> !wake_int_reg[1];
    endproperty
    a_isr_clear: assert property (p_isr_clear) else $error("status read kept wake"); // R4
    property p_resleep;
        @(posedge clock_i) disable iff (!rst_n) !sleep_reg && quiet && !wake_evt |=> sleep_reg;
    endproperty
    a_resleep: assert property (p_resleep) else $error("no return to sleep"); // R5
    property p_iso_needs_sleep;
        @(posedge clock_i) disable iff (!rst_n) isolate_reg |-> $past(sleep_reg && s_iso_pin);
    endproperty
    a_iso_needs_sleep: assert property (p_iso_needs_sleep) else $error("bad isolation"); // R8
    property p_iso_blocks;
        @(posedge clock_i) disable iff (!rst_n)
            isolate_reg |=> !data_oe_o && thr_load_o == 2'h0;
    endproperty
    a_iso_blocks: assert property (p_iso_blocks) else $error("bus leaked in isolation"); // R9
    property p_loop_tx;
        @(posedge clock_i) disable iff (!rst_n) loop[0] |=> tx_o[0] && rts_n_o[0];
    endproperty
    a_loop_tx: assert property (p_loop_tx) else $error("loopback pins moved"); // R15
endmodule

// ===== hw/duart_pkg.sv
// Shared constants and types for the dual UART sleep, loopback and register decode block
package duart_pkg;
    // ==========================================================
    // Register addresses on the three address lines
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SPR = 3'h7;
    // ==========================================================
    // Index of each writable register inside a channel's storage
    localparam logic [3:0] IX_THR = 4'h0;
    localparam logic [3:0] IX_DLL = 4'h1;
    localparam logic [3:0] IX_DLM = 4'h2;
    localparam logic [3:0] IX_DLD = 4'h3;
    localparam logic [3:0] IX_IER = 4'h4;
    localparam logic [3:0] IX_FCR = 4'h5;
    localparam logic [3:0] IX_LCR = 4'h6;
    localparam logic [3:0] IX_MCR = 4'h7;
    localparam logic [3:0] IX_SPR = 4'h8;
    localparam logic [3:0] IX_EMS = 4'h9;
    localparam logic [3:0] IX_TRG = 4'hA;
    localparam logic [3:0] IX_FCT = 4'hB;
    localparam logic [3:0] IX_EFR = 4'hC;
    localparam logic [3:0] IX_XN1 = 4'hD;
    localparam logic [3:0] IX_XN2 = 4'hE;
    localparam logic [3:0] IX_XF1 = 4'hF;
    localparam logic [3:0] IX_XF2 = 4'h0;
    localparam int NUM_REGS = 17;
    // ==========================================================
    // Field positions and special values
    localparam int LCR_DIV_BIT = 7;
    localparam logic [7:0] LCR_ENHANCED = 8'hBF;
    localparam int EFR_ENH_BIT = 4;
    localparam int EFR_CTS_BIT = 7;
    localparam int EFR_RTS_BIT = 6;
    localparam int IER_SLEEP_BIT = 4;
    localparam int MCR_LOOP_BIT = 4;
    localparam int FEATURE_CONTROL_LVL_BIT = 6;
    localparam logic [3:0] ISR_WAKE_CODE = 4'h1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] DIV_ZERO = 8'h00;
    // ==========================================================
    // Modem inputs of one channel, as active-high levels
    typedef struct packed {
        logic carrier_detect;
        logic phone_call_in;
        logic set_ready;
        logic clear_to_send;
    } modem_type;
    // Read-only values supplied by a channel's UART core
    typedef struct packed {
        logic [7:0] rx_data;
        logic [7:0] line_status;
        logic [7:0] int_status;
        logic [7:0] fifo_count;
        logic [7:0] fifo_level;
    } core_status_type;
endpackage

// ===== dv/host_bus_model.sv
// Host processor model driving the block's strobed register bus
`timescale 1ns/1ns
module host_bus_model (
    input wire logic clock_i,
    input wire logic [7:0] rd_data_i,
    output logic [2:0] addr_o,
    output logic [7:0] data_o,
    output logic sel_a_n_o,
    output logic sel_b_n_o,
    output logic wr_n_o,
    output logic rd_n_o
);
    // ==========================================================
    // Idle bus: no channel selected, strobes high
    initial begin
        addr_o = 3'h0;
        data_o = 8'hFF;
        sel_a_n_o = 1'b1;
        sel_b_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
    end
    // One access; strobe held 6 clocks since the pins pass two sync flops
    task automatic access(input logic ch, input logic [2:0] a, input logic [7:0] d,
                          input logic wr, output logic [7:0] q);
        @(posedge clock_i);
        addr_o <= a;
        data_o <= d;
        sel_a_n_o <= ch;
        sel_b_n_o <= !ch;
        @(posedge clock_i);
        wr_n_o <= !wr;
        rd_n_o <= wr;
        repeat (6) @(posedge clock_i);
        q = rd_data_i;
        wr_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        repeat (6) @(posedge clock_i);
        sel_a_n_o <= 1'b1;
        sel_b_n_o <= 1'b1;
        data_o <= ~d; // A released bus must not show the last byte
    endtask
endmodule

// ===== dv/tb.sv
// Testbench for the sleep, isolation, loopback and register decode block
`timescale 1ns/1ns
module tb;
    import duart_pkg::*;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary value
    localparam logic [7:0] IDENT = 8'hA5; // Arbitrary value
    logic clock_i = 1'b0;
    logic reset_n = 1'b0;
    logic iso_sel = 1'b0;
    logic [1:0] rx = 2'b11;
    logic [1:0] tx_shift = 2'b11;
    modem_type [1:0] modem_n = '1;
    core_status_type [1:0] cst = {2{40'h9660C40000}};
    logic [2:0] addr;
    logic [7:0] wdata, rdata, q;
    logic sel_a_n, sel_b_n, wr_n, rd_n, osc, sleep, isolate, osc_prev, oe;
    logic [1:0] rx_shift, tx, rts_n, dtr_n, thr_load, irq, flow;
    int errors = 0;
    int n_tests = 0;
    int loads = 0;
    int oes = 0;
    int oe_base = 0;
    // ==========================================================
    // Clock, reset and transmit load counter
    always #5 clock_i = ~clock_i;
    initial begin
        repeat (8) @(posedge clock_i);
        reset_n <= 1'b1;
    end
    always @(posedge clock_i) if (thr_load[0] === 1'b1) loads++;
    // Cycles with the data bus driven, to see isolation block it
    always @(posedge clock_i) if (oe === 1'b1) oes++;
    host_bus_model host_bus_model_inst (.clock_i(clock_i), .rd_data_i(rdata), .addr_o(addr),
        .data_o(wdata), .sel_a_n_o(sel_a_n), .sel_b_n_o(sel_b_n), .wr_n_o(wr_n), .rd_n_o(rd_n));
    duart_sleep_ctrl #(.REVISION_VALUE(REV), .IDENT_VALUE(IDENT)) duart_sleep_ctrl_inst (
        .clock_i(clock_i), .reset_n_i(reset_n), .addr_i(addr), .data_i(wdata), .data_o(rdata),
        .data_oe_o(oe), .chan_a_select_n_i(sel_a_n), .chan_b_select_n_i(sel_b_n),
        .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .power_isolate_sel_i(iso_sel),
        .rx_i(rx), .modem_n_i(modem_n), .tx_shift_i(tx_shift), .core_int_i(2'b00),
        .core_status_i(cst), .rx_shift_o(rx_shift), .tx_o(tx), .rts_n_o(rts_n),
        .dtr_n_o(dtr_n), .hw_flow_o(flow), .thr_load_o(thr_load), .int_o(irq),
        .osc_output_o(osc), .sleep_o(sleep), .isolate_o(isolate));
    // ==========================================================
    // Comparison, bus and timing helpers
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
        host_bus_model_inst.access(ch, a, d, 1'b1, q);
    endtask
    task automatic rd(input logic ch, input logic [2:0] a, input logic [7:0] e, input string n);
        host_bus_model_inst.access(ch, a, 8'h00, 1'b0, q);
        check(n, q, e);
    endtask
    task automatic ck(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Both wake flags are serviced, so the status nibble reads the wake code
    task automatic clear_wake();
        rd(0, ADDR_ISR, 8'hC1, "isr_a");
        rd(1, ADDR_ISR, 8'hC1, "isr_b");
    endtask
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clock_i);
        errors++;
        give_verdict();
    end
    // Test sequence
    initial begin
        ck(12);
        wr(0, ADDR_IER, 8'h10);
        wr(1, ADDR_IER, 8'h10);
        ck(10);
        check("sleep", 8'(sleep), 8'h01);
        osc_prev = osc;
        ck(3);
        check("osc_frozen", 8'(osc), 8'(osc_prev));
        @(posedge clock_i) rx[0] <= 1'b0;
        ck(8);
        check("rx_wake", 8'(sleep), 8'h00);
        check("wake_irq", 8'(irq), 8'h03);
        osc_prev = osc;
        ck(1);
        check("osc_run", 8'(osc != osc_prev), 8'h01);
        @(posedge clock_i) rx[0] <= 1'b1;
        clear_wake();
        ck(10);
        check("irq_clear", 8'(irq), 8'h00);
        check("resleep", 8'(sleep), 8'h01);
        $display("Test sleep and receive wake done");
        @(posedge clock_i) modem_n[1].clear_to_send <= 1'b0;
        ck(8);
        check("modem_wake", 8'(sleep), 8'h00);
        clear_wake();
        ck(10);
        check("msr_pending", 8'(sleep), 8'h00);
        rd(1, ADDR_MSR, 8'h11, "msr_b");
        ck(10);
        check("resleep_msr", 8'(sleep), 8'h01);
        $display("Test modem wake done");
        @(posedge clock_i) iso_sel <= 1'b1;
        ck(4);
        check("isolate", 8'(isolate), 8'h01);
        oe_base = oes;
        wr(0, ADDR_DATA, 8'h55);
        check("iso_write", 8'(loads), 8'h00);
        check("iso_sleep", 8'(sleep), 8'h01);
        rd(0, ADDR_ISR, 8'h11, "iso_read");
        check("iso_oe", 8'(oes - oe_base), 8'h00);
        @(posedge clock_i) rx[1] <= 1'b0;
        ck(8);
        check("iso_wake", 8'(isolate), 8'h00);
        @(posedge clock_i) rx[1] <= 1'b1;
        clear_wake();
        ck(10);
        check("iso_again", 8'(isolate), 8'h01);
        @(posedge clock_i) iso_sel <= 1'b0;
        ck(4);
        check("iso_off", 8'(isolate), 8'h00);
        $display("Test isolation done");
        wr(0, ADDR_DATA, 8'h55);
        check("thr_load", 8'(loads), 8'h01);
        check("thr_wake", 8'(sleep), 8'h00);
        clear_wake();
        wr(0, ADDR_IER, 8'h00);
        ck(10);
        check("sleep_off", 8'(sleep), 8'h00);
        oe_base = oes;
        rd(0, ADDR_DATA, 8'h96, "rx_data");
        check("oe_read", 8'(oes - oe_base), 8'h06);
        wr(0, ADDR_SPR, 8'h3C);
        rd(0, ADDR_SPR, 8'h3C, "scratch");
        wr(0, ADDR_LCR, 8'h80);
        rd(0, ADDR_DATA, REV, "revision");
        rd(0, ADDR_IER, IDENT, "ident");
        wr(0, ADDR_LCR, 8'hBF);
        wr(0, ADDR_MCR, 8'h11);
        rd(0, ADDR_MCR, 8'h11, "resume_1");
        wr(0, ADDR_ISR, 8'hD0);
        wr(0, ADDR_IER, 8'h40);
        wr(0, ADDR_LCR, 8'h80);
        wr(0, ADDR_ISR, 8'h2D);
        rd(0, ADDR_ISR, 8'h2D, "fraction");
        wr(0, ADDR_LCR, 8'h00);
        rd(0, ADDR_MCR, 8'h00, "mcr");
        rd(0, ADDR_SPR, 8'h00, "fifo_level");
        check("flow_on", 8'(flow), 8'h01);
        $display("Test register decode done");
        wr(0, ADDR_MCR, 8'h10);
        check("flow_off", 8'(flow), 8'h00);
        @(posedge clock_i) tx_shift[0] <= 1'b0;
        ck(4);
        check("loop_rx0", 8'(rx_shift[0]), 8'h00);
        check("loop_pins", {5'h00, tx[0], rts_n[0], dtr_n[0]}, 8'h07);
        @(posedge clock_i) tx_shift[0] <= 1'b1;
        ck(4);
        check("loop_rx1", 8'(rx_shift[0]), 8'h01);
        $display("Test loopback done");
        give_verdict();
    end
endmodule
